// ---- dv/gcpr_regs_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcpr_regs_bench;
   logic clk, resetn, wr_s, rd_s, bo, irq;
   logic [9:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic [7:0] line_in;
   gcpr_pkg::gcpr_pull_drive_type fp, rp;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   gcpr_regs gcpr_regs_i (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr_s), .reg_rd(rd_s), .reg_rd_byte_en(be), .reg_rdata(rdata),
      .line_in(line_in), .front_line_pull(fp), .rear_line_pull(rp),
      .transfer_byte_order_select(bo), .irq(irq));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic results;
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // A hang ends the run well past the roughly 130 cycles the tests need.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rdc(input logic [9:0] a, input logic [3:0] b, input logic [31:0] e,
      input string nm);
      @(posedge clk);
      addr <= a;
      be <= b;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask
   function automatic logic [31:0] pd(input int s);
      pd = (s == 1) ? 32'h4 : (s == 2) ? 32'h2 : (s == 3) ? 32'h1 : 32'h0;
   endfunction
   initial begin
      logic [9:0] ra [5];
      ra = '{10'h398, 10'h39c, 10'h3a0, 10'h38c, 10'h390};
      resetn = 1'b0;
      addr = 10'h0;
      wdata = 32'h0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      be = 4'h0;
      line_in = 8'h00;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      #1 chk("outputs", 32'h0, {24'h0, fp, rp, bo, irq});
      for (int i = 0; i < 5; i++) rdc(ra[i], 4'hf, 32'h0, "reset value");
      wr(10'h398, 32'hffff_ffff);
      repeat (2) @(posedge clk);
      #1 chk("byte order", 32'h1, {31'h0, bo});
      rdc(10'h398, 4'hf, 32'h3, "config");
      wr(10'h398, 32'h0);
      rdc(10'h398, 4'hf, 32'h0, "config cleared");
      for (int s = 0; s < 4; s++) begin
         wr(10'h39c, s);
         wr(10'h3a0, 32'hffff_fffc | (3 - s));
         repeat (2) @(posedge clk);
         #1 chk("front drive", pd(s), {29'h0, fp});
         chk("rear drive", pd(3 - s), {29'h0, rp});
         rdc(10'h39c, 4'hf, s, "front sel");
         rdc(10'h3a0, 4'hf, 3 - s, "rear sel");
      end
      rdc(10'h3fc, 4'hf, 32'h0, "unmapped");
      wr(10'h390, 32'hff);
      wr(10'h380, 32'hff);
      @(posedge clk);
      line_in <= 8'hff;
      repeat (3) @(posedge clk);
      rdc(10'h38c, 4'hf, 32'hff, "rise flags");
      chk("irq", 32'h1, {31'h0, irq});
      wr(10'h38c, 32'h0);
      rdc(10'h38c, 4'hf, 32'hff, "write zero");
      wr(10'h38c, 32'h1);
      rdc(10'h38c, 4'hf, 32'hfe, "write one");
      rdc(10'h38c, 4'hf, 32'hfe, "read keeps");
      wr(10'h398, 32'h2);
      rdc(10'h38c, 4'h2, 32'hfe, "lane one read");
      rdc(10'h38c, 4'h1, 32'hfe, "lane zero read");
      rdc(10'h38c, 4'hf, 32'h0, "after read");
      repeat (2) @(posedge clk);
      #1 chk("irq clear", 32'h0, {31'h0, irq});
      wr(10'h384, 32'h0f);
      @(posedge clk);
      line_in <= 8'h00;
      repeat (3) @(posedge clk);
      wr(10'h390, 32'h0);
      repeat (2) @(posedge clk);
      #1 chk("irq masked", 32'h0, {31'h0, irq});
      wr(10'h38c, 32'hff);
      rdc(10'h38c, 4'h1, 32'h0f, "fall flags");
      rdc(10'h38c, 4'h1, 32'h0, "read clear");
      // A reset in mid-run must bring the config, pull, status and mask registers and every output back to its reset value.
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 5; i++) rdc(ra[i], 4'hf, 32'h0, "second reset");
      chk("outputs after reset", 32'h0, {24'h0, fp, rp, bo, irq});
      results();
   end
endmodule
`default_nettype wire

// ---- dv/gcpr_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcpr_regs_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [gcpr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [gcpr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gcpr_pkg::LANE_N-1:0] reg_rd_byte_en,
   input wire logic [gcpr_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [gcpr_pkg::LINE_N-1:0] line_in,
   input wire gcpr_pkg::gcpr_pull_drive_type front_line_pull,
   input wire gcpr_pkg::gcpr_pull_drive_type rear_line_pull,
   input wire logic transfer_byte_order_select,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   function automatic logic [2:0] drv(input logic [1:0] s);
      drv = {s == 2'h1, s == 2'h2, s == 2'h3};
   endfunction
   wire wf = reg_wr && reg_addr == gcpr_pkg::OFS_FRONT_PULL;
   wire wb = reg_wr && reg_addr == gcpr_pkg::OFS_REAR_PULL;
   wire wc = reg_wr && reg_addr == gcpr_pkg::OFS_GLOBAL_CFG;
   wire rp = reg_rd && (reg_addr == gcpr_pkg::OFS_FRONT_PULL ||
      reg_addr == gcpr_pkg::OFS_REAR_PULL);
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   unmapped_read_a: assert property (reg_rd && reg_addr == 10'h3fc |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   pull_rsvd_a: assert property (rp |=> reg_rdata[31:2] == 30'h0)
      else $error("pull reserved bits set");
   // A second write in the cycle after the first would legally replace the value, so the
   // readback and drive checks below only look at a write that is not followed at once by another.
   cfg_readback_a: assert property (
      wc ##1 !wc ##1 (reg_rd && reg_addr == gcpr_pkg::OFS_GLOBAL_CFG)
      |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 3)})
      else $error("config readback wrong");
   byte_order_a: assert property (
      wc |=> transfer_byte_order_select == $past(reg_wdata[0]))
      else $error("byte order output wrong");
   front_drive_a: assert property (
      wf ##1 !wf |=> front_line_pull == drv($past(reg_wdata[1:0], 2)))
      else $error("front pull drive wrong");
   rear_drive_a: assert property (
      wb ##1 !wb |=> rear_line_pull == drv($past(reg_wdata[1:0], 2)))
      else $error("rear pull drive wrong");
   one_reference_a: assert property ($onehot0(front_line_pull) && $onehot0(rear_line_pull))
      else $error("pull reference not single");
   mask_quiet_a: assert property (reg_wr && reg_addr == gcpr_pkg::OFS_INT_MASK
      && reg_wdata[7:0] == 8'h00 |-> ##2 !irq)
      else $error("masked interrupt still high");
   cover property (reg_rd && reg_addr == gcpr_pkg::OFS_LINE_STATUS);
   cover property ($rose(irq));
   cover property (wf && reg_wdata[1:0] == 2'h3);
endmodule
bind gcpr_regs gcpr_regs_props gcpr_regs_props_i (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rd_byte_en(reg_rd_byte_en), .reg_rdata(reg_rdata), .line_in(line_in),
   .front_line_pull(front_line_pull), .rear_line_pull(rear_line_pull),
   .transfer_byte_order_select(transfer_byte_order_select), .irq(irq));
`default_nettype wire

// ---- logic/gcpr_line_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcpr_line_edge (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [gcpr_pkg::LINE_N-1:0] line_in,
   input wire logic [gcpr_pkg::LINE_N-1:0] rise_en,
   input wire logic [gcpr_pkg::LINE_N-1:0] fall_en,
   output logic [gcpr_pkg::LINE_N-1:0] edge_event
);

   logic [gcpr_pkg::LINE_N-1:0] prev_ff;
   logic armed_ff;

   // The first sample after reset only primes the history, so a line that
   // is already high at release does not report a false rising edge.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         armed_ff <= 1'b0;
      end else begin
         armed_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev_ff <= gcpr_pkg::LINE_REG_RST;
      end else begin
         prev_ff <= line_in;
      end
   end

   genvar i;
   generate
      for (i = 0; i < gcpr_pkg::LINE_N; i = i + 1) begin : g_line
         assign edge_event[i] = armed_ff &
            ((rise_en[i] & line_in[i] & ~prev_ff[i]) |
             (fall_en[i] & ~line_in[i] & prev_ff[i]));
      end
   endgenerate

endmodule
`default_nettype wire

// ---- logic/gcpr_pkg.sv ----
package gcpr_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int LINE_N = 8;
   localparam int LANE_N = 4;
   localparam int LANE_W = 8;
   localparam int PULL_SEL_W = 2;

   localparam logic [ADDR_W-1:0] OFS_RISE_EN = 10'h380;
   localparam logic [ADDR_W-1:0] OFS_FALL_EN = 10'h384;
   localparam logic [ADDR_W-1:0] OFS_LINE_STATUS = 10'h38c;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK = 10'h390;
   localparam logic [ADDR_W-1:0] OFS_GLOBAL_CFG = 10'h398;
   localparam logic [ADDR_W-1:0] OFS_FRONT_PULL = 10'h39c;
   localparam logic [ADDR_W-1:0] OFS_REAR_PULL = 10'h3a0;

   localparam int CFG_BYTE_ORDER_BIT = 0;
   localparam int CFG_ACK_MODE_BIT = 1;

   localparam logic CFG_BYTE_ORDER_RST = 1'h0;
   localparam logic CFG_ACK_MODE_RST = 1'h0;
   localparam logic ACK_CLEAR_BY_WRITE = 1'h0;
   localparam logic ACK_CLEAR_ON_READ = 1'h1;
   localparam logic [LINE_N-1:0] LINE_REG_RST = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

   typedef enum logic [PULL_SEL_W-1:0] {
      GCPR_PULL_FLOAT = 2'h0,
      GCPR_PULL_UP_5V = 2'h1,
      GCPR_PULL_UP_3V3 = 2'h2,
      GCPR_PULL_DOWN_GND = 2'h3
   } gcpr_pull_sel_type;

   localparam gcpr_pull_sel_type PULL_SEL_RST = GCPR_PULL_FLOAT;

   // One switch per reference rail; at most one is closed at a time.
   typedef struct packed {
      logic to_5v;
      logic to_3v3;
      logic to_gnd;
   } gcpr_pull_drive_type;

   typedef enum logic [2:0] {
      GCPR_REG_NONE,
      GCPR_REG_RISE_EN,
      GCPR_REG_FALL_EN,
      GCPR_REG_LINE_STATUS,
      GCPR_REG_INT_MASK,
      GCPR_REG_GLOBAL_CFG,
      GCPR_REG_FRONT_PULL,
      GCPR_REG_REAR_PULL
   } gcpr_reg_type;

endpackage

// ---- logic/gcpr_pull_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcpr_pull_drive (
   input wire logic clk,
   input wire logic resetn,
   input wire gcpr_pkg::gcpr_pull_sel_type sel,
   output gcpr_pkg::gcpr_pull_drive_type drive
);

   gcpr_pkg::gcpr_pull_drive_type nxt_drive;
   gcpr_pkg::gcpr_pull_drive_type drive_ff;

   always_comb begin
      nxt_drive = '0;
      unique case (sel)
         gcpr_pkg::GCPR_PULL_FLOAT: nxt_drive = '0;
         gcpr_pkg::GCPR_PULL_UP_5V: nxt_drive.to_5v = 1'b1;
         gcpr_pkg::GCPR_PULL_UP_3V3: nxt_drive.to_3v3 = 1'b1;
         gcpr_pkg::GCPR_PULL_DOWN_GND: nxt_drive.to_gnd = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         drive_ff <= '0;
      end else begin
         drive_ff <= nxt_drive;
      end
   end

   assign drive = drive_ff;

endmodule
`default_nettype wire

// ---- logic/gcpr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module gcpr_regs (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [gcpr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [gcpr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [gcpr_pkg::LANE_N-1:0] reg_rd_byte_en,
   output logic [gcpr_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [gcpr_pkg::LINE_N-1:0] line_in,
   output gcpr_pkg::gcpr_pull_drive_type front_line_pull,
   output gcpr_pkg::gcpr_pull_drive_type rear_line_pull,
   output logic transfer_byte_order_select,
   output logic irq
);

   // Address decode, shared by the write path and the read path.
   function automatic gcpr_pkg::gcpr_reg_type reg_decode(
      input logic [gcpr_pkg::ADDR_W-1:0] addr
   );
      gcpr_pkg::gcpr_reg_type sel;
      sel = gcpr_pkg::GCPR_REG_NONE;
      unique case (addr)
         gcpr_pkg::OFS_RISE_EN: sel = gcpr_pkg::GCPR_REG_RISE_EN;
         gcpr_pkg::OFS_FALL_EN: sel = gcpr_pkg::GCPR_REG_FALL_EN;
         gcpr_pkg::OFS_LINE_STATUS: sel = gcpr_pkg::GCPR_REG_LINE_STATUS;
         gcpr_pkg::OFS_INT_MASK: sel = gcpr_pkg::GCPR_REG_INT_MASK;
         gcpr_pkg::OFS_GLOBAL_CFG: sel = gcpr_pkg::GCPR_REG_GLOBAL_CFG;
         gcpr_pkg::OFS_FRONT_PULL: sel = gcpr_pkg::GCPR_REG_FRONT_PULL;
         gcpr_pkg::OFS_REAR_PULL: sel = gcpr_pkg::GCPR_REG_REAR_PULL;
         default: sel = gcpr_pkg::GCPR_REG_NONE;
      endcase
      return sel;
   endfunction

   // Expands byte enables into a bit mask over one data word.
   function automatic logic [gcpr_pkg::DATA_W-1:0] lane_mask(
      input logic [gcpr_pkg::LANE_N-1:0] be
   );
      logic [gcpr_pkg::DATA_W-1:0] m;
      m = '0;
      for (int k = 0; k < gcpr_pkg::LANE_N; k++) begin
         m[k*gcpr_pkg::LANE_W +: gcpr_pkg::LANE_W] = {gcpr_pkg::LANE_W{be[k]}};
      end
      return m;
   endfunction

   gcpr_pkg::gcpr_reg_type wr_sel;
   gcpr_pkg::gcpr_reg_type rd_sel;

   logic ack_mode_ff;
   logic byte_order_ff;
   gcpr_pkg::gcpr_pull_sel_type front_sel_ff;
   gcpr_pkg::gcpr_pull_sel_type rear_sel_ff;
   logic [gcpr_pkg::LINE_N-1:0] rise_en_ff;
   logic [gcpr_pkg::LINE_N-1:0] fall_en_ff;
   logic [gcpr_pkg::LINE_N-1:0] int_mask_ff;
   logic [gcpr_pkg::LINE_N-1:0] line_edge_event_flag_ff;
   logic [gcpr_pkg::LINE_N-1:0] nxt_line_edge_event_flag;
   logic [gcpr_pkg::LINE_N-1:0] edge_event;
   logic [gcpr_pkg::LINE_N-1:0] write_clear;
   logic [gcpr_pkg::LINE_N-1:0] read_clear;
   logic [gcpr_pkg::LINE_N-1:0] rd_lane_bits;
   logic [gcpr_pkg::DATA_W-1:0] rd_mask;
   logic [gcpr_pkg::DATA_W-1:0] nxt_rdata;
   logic [gcpr_pkg::DATA_W-1:0] rdata_ff;
   logic irq_ff;

   assign wr_sel = reg_decode(reg_addr);
   assign rd_sel = reg_decode(reg_addr);

   // Global configuration: acknowledge mode and byte order.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_mode_ff <= gcpr_pkg::CFG_ACK_MODE_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_GLOBAL_CFG) begin
         ack_mode_ff <= reg_wdata[gcpr_pkg::CFG_ACK_MODE_BIT];
      end
   end

   // The byte order only leaves this block as a level; the transfer engine
   // that honours it lives elsewhere.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         byte_order_ff <= gcpr_pkg::CFG_BYTE_ORDER_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_GLOBAL_CFG) begin
         byte_order_ff <= reg_wdata[gcpr_pkg::CFG_BYTE_ORDER_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         front_sel_ff <= gcpr_pkg::PULL_SEL_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_FRONT_PULL) begin
         front_sel_ff <= gcpr_pkg::gcpr_pull_sel_type'(reg_wdata[gcpr_pkg::PULL_SEL_W-1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rear_sel_ff <= gcpr_pkg::PULL_SEL_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_REAR_PULL) begin
         rear_sel_ff <= gcpr_pkg::gcpr_pull_sel_type'(reg_wdata[gcpr_pkg::PULL_SEL_W-1:0]);
      end
   end

   // Edge enables select which transitions of each line raise its flag.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rise_en_ff <= gcpr_pkg::LINE_REG_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_RISE_EN) begin
         rise_en_ff <= reg_wdata[gcpr_pkg::LINE_N-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fall_en_ff <= gcpr_pkg::LINE_REG_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_FALL_EN) begin
         fall_en_ff <= reg_wdata[gcpr_pkg::LINE_N-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         int_mask_ff <= gcpr_pkg::LINE_REG_RST;
      end else if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_INT_MASK) begin
         int_mask_ff <= reg_wdata[gcpr_pkg::LINE_N-1:0];
      end
   end

   gcpr_line_edge u_line_edge (
      .clk(clk),
      .resetn(resetn),
      .line_in(line_in),
      .rise_en(rise_en_ff),
      .fall_en(fall_en_ff),
      .edge_event(edge_event)
   );

   // A write to the status register only clears in clear-by-write mode; in
   // clear-on-read mode such a write is ignored so that a stray store cannot
   // drop an event software has not seen yet.
   always_comb begin
      write_clear = '0;
      if (reg_wr && wr_sel == gcpr_pkg::GCPR_REG_LINE_STATUS &&
          ack_mode_ff == gcpr_pkg::ACK_CLEAR_BY_WRITE) begin
         write_clear = reg_wdata[gcpr_pkg::LINE_N-1:0];
      end
   end

   assign rd_mask = lane_mask(reg_rd_byte_en);
   assign rd_lane_bits = rd_mask[gcpr_pkg::LINE_N-1:0];

   always_comb begin
      read_clear = '0;
      if (reg_rd && rd_sel == gcpr_pkg::GCPR_REG_LINE_STATUS &&
          ack_mode_ff == gcpr_pkg::ACK_CLEAR_ON_READ) begin
         read_clear = rd_lane_bits;
      end
   end

   // An edge in the same cycle as the clear survives: set wins over clear.
   always_comb begin
      nxt_line_edge_event_flag = (line_edge_event_flag_ff & ~(write_clear | read_clear)) |
         edge_event;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         line_edge_event_flag_ff <= gcpr_pkg::LINE_REG_RST;
      end else begin
         line_edge_event_flag_ff <= nxt_line_edge_event_flag;
      end
   end

   // Level interrupt, one cycle behind the flags and mask it reflects.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(line_edge_event_flag_ff & int_mask_ff);
      end
   end

   // Read data show the value before any clear the same read causes.
   always_comb begin
      nxt_rdata = '0;
      unique case (rd_sel)
         gcpr_pkg::GCPR_REG_NONE: nxt_rdata = '0;
         gcpr_pkg::GCPR_REG_RISE_EN: nxt_rdata[gcpr_pkg::LINE_N-1:0] = rise_en_ff;
         gcpr_pkg::GCPR_REG_FALL_EN: nxt_rdata[gcpr_pkg::LINE_N-1:0] = fall_en_ff;
         gcpr_pkg::GCPR_REG_LINE_STATUS: begin
            nxt_rdata[gcpr_pkg::LINE_N-1:0] = line_edge_event_flag_ff;
         end
         gcpr_pkg::GCPR_REG_INT_MASK: nxt_rdata[gcpr_pkg::LINE_N-1:0] = int_mask_ff;
         gcpr_pkg::GCPR_REG_GLOBAL_CFG: begin
            nxt_rdata[gcpr_pkg::CFG_ACK_MODE_BIT] = ack_mode_ff;
            nxt_rdata[gcpr_pkg::CFG_BYTE_ORDER_BIT] = byte_order_ff;
         end
         gcpr_pkg::GCPR_REG_FRONT_PULL: nxt_rdata[gcpr_pkg::PULL_SEL_W-1:0] = front_sel_ff;
         gcpr_pkg::GCPR_REG_REAR_PULL: nxt_rdata[gcpr_pkg::PULL_SEL_W-1:0] = rear_sel_ff;
      endcase
   end

   // Read data stand only in the cycle after the strobe, zero otherwise.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_ff <= gcpr_pkg::RDATA_RST;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= gcpr_pkg::RDATA_RST;
      end
   end

   gcpr_pull_drive u_front_pull (
      .clk(clk),
      .resetn(resetn),
      .sel(front_sel_ff),
      .drive(front_line_pull)
   );

   gcpr_pull_drive u_rear_pull (
      .clk(clk),
      .resetn(resetn),
      .sel(rear_sel_ff),
      .drive(rear_line_pull)
   );

   assign reg_rdata = rdata_ff;
   assign transfer_byte_order_select = byte_order_ff;
   assign irq = irq_ff;

endmodule
`default_nettype wire
